// ===== hdl/capture_timer_defs.vh
// constants of the capture timer: register indices, fields, modes, reset values
// assumes inclusion by bare name from the design file
`ifndef CAPTURE_TIMER_DEFS_VH
`define CAPTURE_TIMER_DEFS_VH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define IDX_CONTROL_A        6'h00
`define IDX_CONTROL_B        6'h01
`define IDX_EVENT_CONTROL    6'h04
`define IDX_INTERRUPT_ENABLE 6'h05
`define IDX_INTERRUPT_FLAGS  6'h06
`define IDX_RUN_STATE        6'h07
`define IDX_DEBUG_CONTROL    6'h08
`define IDX_BYTE_LATCH       6'h09
`define IDX_COUNT_VALUE      6'h0a
`define IDX_COMPARE_CAPTURE  6'h0c
`define CAPTURE_FLAG_VECTOR_OFFSET   8'h00

// ****************************************
// field positions
// ****************************************
`define CA_ENABLE            0
`define CA_CLOCK_SOURCE_SEL_LO         1
`define CA_CLOCK_SOURCE_SEL_HI         2
`define CA_RESTART_COMP      4
`define CA_RUN_STDBY         6
`define CB_MODE_LO           0
`define CB_MODE_HI           2
`define CB_OUT_EN            4
`define CB_OUT_INIT          5
`define CB_OUT_SEL_A         6
`define EC_INPUT_EN          0
`define EC_EDGE              4
`define EC_FILTER            6
`define FLAG_BIT             0

// ****************************************
// writable masks and reset values
// ****************************************
`define MASK_CONTROL_A       8'h57
`define MASK_CONTROL_B       8'h77
`define MASK_EVENT_CONTROL   8'h51
`define MASK_BIT0            8'h01
`define RESET_BYTE           8'h00
`define RESET_WORD           16'h0000

// ****************************************
// count modes and clock sources
// ****************************************
`define MODE_PERIODIC        3'h0
`define MODE_TIMEOUT         3'h1
`define MODE_CAPTURE         3'h2
`define MODE_FREQ            3'h3
`define MODE_PULSE_WIDTH     3'h4
`define MODE_FREQ_PW         3'h5
`define MODE_SINGLE_SHOT     3'h6
`define MODE_PWM8            3'h7
`define CLK_PER              2'h0
`define CLK_PER_HALF         2'h1
`define CLK_COMPANION        2'h2

`endif

// ===== hdl/capture_timer.v
// 16-bit capture/compare timer with apb register slave, event in/out and irq line
// assumes companion timer signals and sleep levels come from logic on pclk,
// while event_in is asynchronous and is synchronised here
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "capture_timer_defs.vh"

module capture_timer #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input  wire              pclk,
    input  wire              presetn,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // event network
    input  wire              event_in,
    output reg               event_out,
    // companion timer
    input  wire              companion_timer_clock,
    input  wire              companion_restart,
    // sleep and debug state
    input  wire              sleep_standby,
    input  wire              sleep_powerdown,
    input  wire              debug_halt,
    // outputs
    output reg               compare_out,
    output reg               irq
);

    // ****************************************
    // registers
    // ****************************************
    reg  [7:0]  control_a;
    reg  [7:0]  control_b;
    reg  [7:0]  event_control;
    reg  [7:0]  interrupt_enable;
    reg  [7:0]  debug_control;
    reg  [7:0]  byte_latch;
    reg  [15:0] count_value;
    reg  [15:0] compare_capture_value;
    reg         capture_flag;
    reg         run;
    reg         half_phase;
    reg  [1:0]  fpw_phase;
    reg         pwm_level;
    reg         sync_a;
    reg         sync_b;
    reg  [3:0]  samples;
    reg         filt;
    reg         evt_prev;

    // ****************************************
    // decode
    // ****************************************
    wire [5:0]  idx      = paddr[7:2];
    wire        aligned  = (paddr[1:0] == 2'b00);
    wire        setup    = psel & ~penable;
    wire        wr       = psel & penable & pready & pwrite & ~pslverr;
    wire        rd_done  = psel & penable & pready & ~pwrite & ~pslverr;
    wire        enable   = control_a[`CA_ENABLE];
    wire [1:0]  clk_sel  = control_a[`CA_CLOCK_SOURCE_SEL_HI:`CA_CLOCK_SOURCE_SEL_LO];
    wire [2:0]  count_mode_field = control_b[`CB_MODE_HI:`CB_MODE_LO];
    wire        compare_output_enable = control_b[`CB_OUT_EN];
    wire        output_initial_level  = control_b[`CB_OUT_INIT];
    wire        output_sel_a          = control_b[`CB_OUT_SEL_A];
    wire        event_input_enable    = event_control[`EC_INPUT_EN];
    wire        edge_sel = event_control[`EC_EDGE];
    wire        filter_en = event_control[`EC_FILTER];
    wire        restart_with_companion = control_a[`CA_RESTART_COMP];
    wire        run_in_standby = control_a[`CA_RUN_STDBY];
    wire        run_while_debug = debug_control[`FLAG_BIT];

    function mapped;
        input [5:0] i;
        begin
            mapped = (i == `IDX_CONTROL_A) || (i == `IDX_CONTROL_B) ||
                     (i == `IDX_EVENT_CONTROL) || (i == `IDX_INTERRUPT_ENABLE) ||
                     (i == `IDX_INTERRUPT_FLAGS) || (i == `IDX_RUN_STATE) ||
                     (i == `IDX_DEBUG_CONTROL) || (i == `IDX_BYTE_LATCH) ||
                     (i == `IDX_COUNT_VALUE) || (i == `IDX_COMPARE_CAPTURE);
        end
    endfunction

    // ****************************************
    // sleep gating and counter tick
    // ****************************************
    wire halted = ~enable | sleep_powerdown
                | (sleep_standby & ~run_in_standby)
                | (debug_halt & ~run_while_debug);
    reg tick;
    always @* begin
        case (clk_sel)
            `CLK_PER:       tick = ~halted;
            `CLK_PER_HALF:  tick = ~halted & half_phase;
            `CLK_COMPANION: tick = ~halted & companion_timer_clock;
            default:        tick = 1'b0;
        endcase
    end

    // ****************************************
    // event input: filter and edges
    // ****************************************
    // the filter looks at sync_b only, never at the first stage
    wire stable    = (samples == 4'hf) | (samples == 4'h0);
    wire evt_level = filter_en ? filt : sync_b;
    wire rise      = evt_level & ~evt_prev;
    wire fall      = ~evt_level & evt_prev;
    wire act_en    = event_input_enable & ~halted;
    wire act       = act_en & (edge_sel ? fall : rise);
    wire opp       = act_en & (edge_sel ? rise : fall);

    // ****************************************
    // count modes
    // ****************************************
    reg [15:0] next_count;
    reg [15:0] next_compare_capture_value;
    reg        next_run;
    reg        next_pwm;
    reg [1:0]  next_phase;
    reg        set_flag;
    reg        trig;
    always @* begin
        next_count = count_value;
        next_compare_capture_value  = compare_capture_value;
        next_run   = run;
        next_pwm   = pwm_level;
        next_phase = fpw_phase;
        set_flag   = 1'b0;
        trig       = 1'b0;
        case (count_mode_field)
            `MODE_PERIODIC: begin
                next_run = ~halted;
                if (tick) begin
                    if (count_value == compare_capture_value) begin
                        next_count = `RESET_WORD;
                        set_flag   = 1'b1;
                    end else
                        next_count = count_value + 16'h0001;
                end
            end
            `MODE_TIMEOUT: begin
                if (tick && run) begin
                    next_count = count_value + 16'h0001;
                    if (next_count == compare_capture_value)
                        set_flag = 1'b1;
                end
                if (act) begin
                    next_count = `RESET_WORD;
                    next_run   = 1'b1;
                end else if (opp)
                    next_run = 1'b0;
            end
            `MODE_CAPTURE, `MODE_FREQ: begin
                next_run = ~halted;
                if (tick)
                    next_count = count_value + 16'h0001;
                if (act) begin
                    next_compare_capture_value = count_value;
                    set_flag  = 1'b1;
                    if (count_mode_field == `MODE_FREQ)
                        next_count = `RESET_WORD;
                end
            end
            `MODE_PULSE_WIDTH: begin
                next_run = ~halted;
                if (tick)
                    next_count = count_value + 16'h0001;
                if (act)
                    next_count = `RESET_WORD;
                else if (opp) begin
                    next_compare_capture_value = count_value;
                    set_flag  = 1'b1;
                end
            end
            `MODE_FREQ_PW: begin
                if (tick && run)
                    next_count = count_value + 16'h0001;
                case (fpw_phase)
                    2'h0: if (act) begin
                        next_count = `RESET_WORD;
                        next_run   = 1'b1;
                        next_phase = 2'h1;
                    end
                    2'h1: if (opp) begin
                        next_compare_capture_value  = count_value;
                        next_phase = 2'h2;
                    end
                    2'h2: if (act) begin
                        next_run   = 1'b0;
                        set_flag   = 1'b1;
                        next_phase = 2'h3;
                    end
                    default: if (!capture_flag)
                        next_phase = 2'h0;
                endcase
            end
            `MODE_SINGLE_SHOT: begin
                // events while running are ignored
                if (run) begin
                    if (tick) begin
                        if (count_value == compare_capture_value) begin
                            next_run = 1'b0;
                            set_flag = 1'b1;
                        end else
                            next_count = count_value + 16'h0001;
                    end
                end else if (act) begin
                    trig       = 1'b1;
                    next_count = `RESET_WORD;
                    next_run   = 1'b1;
                end
            end
            default: begin
                next_run = ~halted;
                if (tick) begin
                    if (count_value[7:0] == compare_capture_value[7:0]) begin
                        next_count = `RESET_WORD;
                        set_flag   = 1'b1;
                    end else
                        next_count = {8'h00, count_value[7:0] + 8'h01};
                    if (next_count[7:0] == 8'h00)
                        next_pwm = (compare_capture_value[15:8] != 8'h00);
                    else if (next_count[7:0] == compare_capture_value[15:8])
                        next_pwm = 1'b0;
                end
            end
        endcase
        if (tick && restart_with_companion && companion_restart)
            next_count = `RESET_WORD;
        if (!enable)
            next_run = 1'b0;
    end

    // flag: hardware set beats w1c clear and the read-clear of capture data
    wire clr_flag = (wr && idx == `IDX_INTERRUPT_FLAGS && pwdata[`FLAG_BIT]) ||
                    (rd_done && idx == `IDX_COMPARE_CAPTURE);
    wire next_flag = set_flag | (capture_flag & ~clr_flag);

    reg next_out;
    always @* begin
        if (!compare_output_enable)
            next_out = 1'b0;
        else if (count_mode_field == `MODE_SINGLE_SHOT)
            next_out = output_sel_a ? (next_run | trig)
                                    : run;
        else if (count_mode_field == `MODE_PWM8)
            next_out = pwm_level;
        else
            next_out = output_initial_level;
    end

    reg [31:0] rdata;
    always @* begin
        case (idx)
            `IDX_CONTROL_A:        rdata = {24'h0, control_a};
            `IDX_CONTROL_B:        rdata = {24'h0, control_b};
            `IDX_EVENT_CONTROL:    rdata = {24'h0, event_control};
            `IDX_INTERRUPT_ENABLE: rdata = {24'h0, interrupt_enable};
            `IDX_INTERRUPT_FLAGS:  rdata = {31'h0, capture_flag};
            `IDX_RUN_STATE:        rdata = {31'h0, run};
            `IDX_DEBUG_CONTROL:    rdata = {24'h0, debug_control};
            `IDX_BYTE_LATCH:       rdata = {24'h0, byte_latch};
            `IDX_COUNT_VALUE:      rdata = {16'h0, count_value};
            `IDX_COMPARE_CAPTURE:  rdata = {16'h0, compare_capture_value};
            default:               rdata = 32'h0;
        endcase
    end

    // ****************************************
    // sequential state
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_a             <= `RESET_BYTE;
            control_b             <= `RESET_BYTE;
            event_control         <= `RESET_BYTE;
            interrupt_enable      <= `RESET_BYTE;
            debug_control         <= `RESET_BYTE;
            byte_latch            <= `RESET_BYTE;
            count_value           <= `RESET_WORD;
            compare_capture_value <= `RESET_WORD;
            capture_flag          <= 1'b0;
            run                   <= 1'b0;
            half_phase            <= 1'b0;
            fpw_phase             <= 2'h0;
            pwm_level             <= 1'b0;
            sync_a                <= 1'b0;
            sync_b                <= 1'b0;
            samples               <= 4'h0;
            filt                  <= 1'b0;
            evt_prev              <= 1'b0;
            prdata                <= 32'h0;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            event_out             <= 1'b0;
            compare_out           <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            sync_a   <= event_in;
            sync_b   <= sync_a;
            samples  <= {samples[2:0], sync_b};
            if (stable)
                filt <= samples[3];
            evt_prev <= evt_level;
            half_phase <= halted ? 1'b0 : ~half_phase;
            // no wait state: ready and read data are prepared in setup
            pready  <= setup;
            pslverr <= setup & ~(aligned & mapped(idx));
            prdata  <= setup ? rdata : 32'h0;
            count_value           <= next_count;
            compare_capture_value <= next_compare_capture_value;
            run       <= next_run;
            pwm_level <= next_pwm;
            fpw_phase <= next_phase;
            capture_flag <= next_flag;
            event_out    <= set_flag;
            irq          <= next_flag & interrupt_enable[`FLAG_BIT];
            compare_out  <= next_out;
            if (wr) begin
                case (idx)
                    `IDX_CONTROL_A:        control_a <= pwdata[7:0] & `MASK_CONTROL_A;
                    `IDX_CONTROL_B:        control_b <= pwdata[7:0] & `MASK_CONTROL_B;
                    `IDX_EVENT_CONTROL:    event_control <= pwdata[7:0] & `MASK_EVENT_CONTROL;
                    `IDX_INTERRUPT_ENABLE: interrupt_enable <= pwdata[7:0] & `MASK_BIT0;
                    `IDX_DEBUG_CONTROL:    debug_control <= pwdata[7:0] & `MASK_BIT0;
                    `IDX_BYTE_LATCH:       byte_latch <= pwdata[7:0];
                    `IDX_COUNT_VALUE:      count_value <= pwdata[15:0];
                    `IDX_COMPARE_CAPTURE:  compare_capture_value <= pwdata[15:0];
                    default:               byte_latch <= byte_latch;
                endcase
            end
        end
    end

endmodule // capture_timer

// ===== testbench/capture_timer_checker.sv
// checker: timing relations at the ports of the capture timer
// assumes apb writes land at the access edge, as the register slave does
`timescale 1ns/1ps
module capture_timer_checker #(parameter ADDR_W = 8) (
    // clock, reset and apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // state and outputs
    input wire logic              sleep_standby,
    input wire logic              sleep_powerdown,
    input wire logic              event_out,
    input wire logic              compare_out,
    input wire logic              irq
);
    // ****************************************
    // shadow copies of the control bytes
    // ****************************************
    wire       acc = psel && penable && pready;
    wire       wr_acc = acc && pwrite && !pslverr;
    logic [7:0] ca, cb, ec;
    logic       ie;
    logic [3:0] quiet;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ca <= 8'h00;
            cb <= 8'h00;
            ec <= 8'h00;
            ie <= 1'b0;
            quiet <= 4'h0;
        end else begin
            // settle time after any write, so register latency never trips a check
            quiet <= wr_acc ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
            if (wr_acc && paddr == 8'h00) ca <= pwdata[7:0];
            if (wr_acc && paddr == 8'h04) cb <= pwdata[7:0];
            if (wr_acc && paddr == 8'h10) ec <= pwdata[7:0];
            if (wr_acc && paddr == 8'h14) ie <= pwdata[0];
        end
    end
    default clocking dclk @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_event_one_cycle: assert property (event_out |=> !event_out)
        else $error("event strobe longer than one cycle");
    chk_irq_needs_enable: assert property (quiet > 4'h2 && !ie |-> !irq)
        else $error("irq high with capture interrupt disabled");
    chk_irq_holds: assert property (irq && !acc && !$past(acc) |=> irq)
        else $error("irq dropped without flag clear");
    chk_out_disabled: assert property (quiet > 4'h2 && !cb[4] |-> !compare_out)
        else $error("compare output high while disabled");
    chk_out_init_level: assert property (quiet > 4'h2 && cb[4] && cb[2:0] < 3'h6
        |-> compare_out == cb[5])
        else $error("compare output not at initial level");
    chk_pdown_silent: assert property (sleep_powerdown [*3] |-> !event_out)
        else $error("event strobe in power-down");
    chk_stby_halted: assert property ((sleep_standby && !ca[6]) [*3] |-> !event_out)
        else $error("event strobe in standby without run bit");
    chk_input_off: assert property (quiet > 4'h4 && !ec[0] && cb[2:0] == 3'h2
        |-> !event_out)
        else $error("capture with event input disabled");
    cover property ($rose(irq));
    cover property ($rose(compare_out));
    cover property (event_out);
endmodule // capture_timer_checker
bind capture_timer capture_timer_checker #(.ADDR_W(ADDR_W)) capture_timer_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown),
    .event_out(event_out), .compare_out(compare_out), .irq(irq));

// ===== testbench/companion_model.sv
// model of the companion timer ticks and the event network source
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module companion_model (
    // clock
    input  wire logic pclk,
    // toward the timer
    output logic      companion_timer_clock,
    output logic      companion_restart,
    output logic      event_in
);
    initial begin
        companion_timer_clock = 1'b0;
        companion_restart = 1'b0;
        event_in = 1'b0;
    end
    // one tick every second cycle, like a prescaled companion
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk) companion_timer_clock <= 1'b1;
            @(posedge pclk) companion_timer_clock <= 1'b0;
        end
    endtask
    // restart only counts together with a tick
    task automatic restart_pulse();
        @(posedge pclk);
        companion_timer_clock <= 1'b1;
        companion_restart <= 1'b1;
        @(posedge pclk);
        companion_timer_clock <= 1'b0;
        companion_restart <= 1'b0;
    endtask
    // each level is held at least one cycle
    task automatic ev(input logic lvl, input int hold);
        @(posedge pclk) event_in <= lvl;
        repeat (hold) @(posedge pclk);
    endtask
endmodule // companion_model

// ===== testbench/tb.sv
// self-checking bench for the capture timer over apb
// assumes the register slave answers with one access cycle
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, sleep_standby, sleep_powerdown, debug_halt;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rnd;
    wire  [31:0] prdata;
    wire         pready, pslverr, event_out, compare_out, irq, tick, rst_c, event_in;
    logic [33:0] expq[$];
    logic [33:0] e;
    int          errors, num_checks, cycles, ev_cnt, exp_ev, hi;
    logic [7:0]  addrs [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
                                8'h28, 8'h30};
    logic [31:0] msk [10] = '{32'h56, 32'h77, 32'h51, 32'h1, 32'h0, 32'h0, 32'h1, 32'hff,
                              32'hffff, 32'hffff};
    capture_timer capture_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .event_in(event_in), .event_out(event_out),
        .companion_timer_clock(tick), .companion_restart(rst_c),
        .sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown),
        .debug_halt(debug_halt), .compare_out(compare_out), .irq(irq));
    companion_model companion_model_inst (.pclk(pclk), .companion_timer_clock(tick),
        .companion_restart(rst_c), .event_in(event_in));
    // ****************************************
    // checking and bus tasks
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        expq.push_back({~w, err, exp});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        repeat (6) @(posedge pclk);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask
    task automatic wait_out(input logic v, input int lim);
        for (int k = 0; k < lim && compare_out !== v; k++) @(posedge pclk);
        check(compare_out, v);
    endtask
    // the watcher pops the oldest note at every completed transfer
    always @(posedge pclk) begin
        cycles++;
        if (event_out === 1'b1) ev_cnt++;
        if (cycles == 20000) begin
            errors++;
            results();
        end else if (psel && penable && pready === 1'b1) begin
            e = expq.pop_front();
            check(pslverr, e[32]);
            if (e[33]) check(prdata, e[31:0]);
        end
    end
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, sleep_standby, sleep_powerdown, debug_halt} = 7'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rnd = 32'h2c00010c;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) apb(1'b0, addrs[i], 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h01, 32'h0, 32'h0, 1'b1);
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            // enable kept off so no counting disturbs the readback
            wr(addrs[i], i == 0 ? rnd & 32'hfffffffe : rnd);
            rd(addrs[i], rnd & msk[i]);
        end
        wr(8'h04, 32'h02);
        wr(8'h10, 32'h01);
        wr(8'h14, 32'h00);
        wr(8'h00, 32'h01);
        companion_model_inst.ev(1'b1, 3);
        companion_model_inst.ev(1'b0, 3);
        rd(8'h18, 32'h1);
        check(irq, 1'b0);
        wr(8'h14, 32'h01);
        repeat (2) @(posedge pclk);
        check(irq, 1'b1);
        wr(8'h18, 32'h01);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        wr(8'h10, 32'h41);
        companion_model_inst.ev(1'b1, 2);
        companion_model_inst.ev(1'b0, 6);
        rd(8'h18, 32'h0);
        companion_model_inst.ev(1'b1, 8);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'h01);
        wr(8'h10, 32'h11);
        companion_model_inst.ev(1'b0, 6);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'h01);
        companion_model_inst.ev(1'b1, 6);
        rd(8'h18, 32'h0);
        wr(8'h10, 32'h10);
        companion_model_inst.ev(1'b0, 6);
        rd(8'h18, 32'h0);
        wr(8'h10, 32'h01);
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, s == 2 ? 32'h41 : 32'h01);
            @(posedge pclk) {sleep_standby, sleep_powerdown} <= (s == 0) ? 2'b01 : 2'b10;
            companion_model_inst.ev(1'b1, 6);
            companion_model_inst.ev(1'b0, 6);
            {sleep_standby, sleep_powerdown} <= 2'b00;
            rd(8'h18, s == 2);
            wr(8'h18, 32'h01);
        end
        check(ev_cnt, 32'd4);
        wr(8'h10, 32'h00);
        for (int m = 0; m < 6; m++) begin
            wr(8'h04, 32'h30 | m);
            repeat (3) @(posedge pclk);
            check(compare_out, 1'b1);
            wr(8'h04, 32'h10 | m);
            repeat (3) @(posedge pclk);
            check(compare_out, 1'b0);
        end
        wr(8'h00, 32'h00);
        wr(8'h28, 32'h0);
        wr(8'h30, 32'h5);
        wr(8'h04, 32'h16);
        wr(8'h10, 32'h01);
        wr(8'h00, 32'h01);
        check(compare_out, 1'b0);
        companion_model_inst.ev(1'b1, 2);
        wait_out(1'b1, 10);
        wait_out(1'b0, 40);
        wr(8'h04, 32'h56);
        companion_model_inst.ev(1'b0, 2);
        companion_model_inst.ev(1'b1, 4);
        check(compare_out, 1'b1);
        wait_out(1'b0, 40);
        wr(8'h00, 32'h00);
        wr(8'h30, 32'h0203);
        wr(8'h28, 32'h0);
        wr(8'h04, 32'h17);
        wr(8'h00, 32'h01);
        repeat (8) @(posedge pclk);
        hi = 0;
        repeat (8) @(posedge pclk) hi += compare_out;
        check(hi, 32'd4);
        wr(8'h00, 32'h00);
        wr(8'h04, 32'h00);
        wr(8'h30, 32'hffff);
        wr(8'h28, 32'h0);
        wr(8'h00, 32'h05);
        rd(8'h28, 32'h0);
        companion_model_inst.tick(4);
        rd(8'h28, 32'h4);
        wr(8'h00, 32'h15);
        companion_model_inst.restart_pulse();
        rd(8'h28, 32'h0);
        results();
    end
endmodule // tb
